// *** rtl/gcsb_defs.svh ***
// register offsets, field positions and reset values of the global bank
`ifndef GCSB_DEFS_SVH
`define GCSB_DEFS_SVH
`define GCSB_ADDR_CFG       7'h00
`define GCSB_ADDR_STAT      7'h01
`define GCSB_ADDR_WCNT      7'h02
`define GCSB_CFG_W          12
`define GCSB_CFG_LOW_W      7
`define GCSB_CFG_RST        12'h000
`define GCSB_CFG_LOW_RST    7'h00
`define GCSB_BIT_TEST       7
`define GCSB_BIT_INV1       8
`define GCSB_BIT_INV2       9
`define GCSB_BIT_LOCK       10
`define GCSB_BIT_SYNC       11
`define GCSB_STAT_W         4
`define GCSB_BIT_RESET      0
`define GCSB_BIT_DRV1       1
`define GCSB_BIT_DRV2       2
`define GCSB_BIT_UV         3
`define GCSB_STAT_RST       4'h1
`define GCSB_CNT_W          8
`define GCSB_CNT_RST        8'h00
`define GCSB_CNT_ONE        8'h01
`define GCSB_CNT_MAX        8'hFF
`define GCSB_DATA_ZERO      32'h0000_0000
`endif

// *** rtl/gcsb_pkg.sv ***
// shared types of the global configuration and status bank
`default_nettype none
package gcsb_pkg;
    typedef logic [6:0]  gcsb_addr_t;
    typedef logic [31:0] gcsb_data_t;
    typedef logic [1:0]  gcsb_sync_t;
endpackage
`default_nettype wire

// *** rtl/gcsb_top.sv ***
// global configuration, clear-on-read status and uart write counter bank
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`include "gcsb_defs.svh"
`default_nettype none
module gcsb_top (
    // clock, reset, enable
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    // register access from the serial frame decoder
    input  wire logic              reg_wr_stb,
    input  wire logic              reg_rd_stb,
    input  wire gcsb_pkg::gcsb_addr_t reg_addr,
    input  wire gcsb_pkg::gcsb_data_t reg_wdata,
    output var  gcsb_pkg::gcsb_data_t reg_rdata_q,
    output logic                   reg_rvalid_q,
    // asynchronous pins and analog comparators
    input  wire logic              uart_mode_pin,
    input  wire logic              drv1_fault_pin,
    input  wire logic              drv2_fault_pin,
    input  wire logic              pump_uv_pin,
    // motion logic on the same clock
    input  wire logic              motor1_dir_req,
    input  wire logic              motor2_dir_req,
    input  wire logic              motor1_load_mode,
    input  wire logic              motor2_load_mode,
    input  wire logic              motor1_slow_req,
    input  wire logic              motor2_slow_req,
    // configuration and control outputs
    output logic [6:0]             cfg_low_q,
    output logic                   analog_test_pin_q,
    output logic                   motor1_dir_q,
    output logic                   motor2_dir_q,
    output logic                   motor1_slow_q,
    output logic                   motor2_slow_q,
    output logic                   driver_disable_q
);
    import gcsb_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    gcsb_sync_t uart_s_q;
    gcsb_sync_t drv1_s_q;
    gcsb_sync_t drv2_s_q;
    gcsb_sync_t uv_s_q;
    logic       uart_mode;
    logic       drv1_err;
    logic       drv2_err;
    logic       pump_uv;

    // stage 0 is read only by stage 1
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            uart_s_q <= 2'h0;
            drv1_s_q <= 2'h0;
            drv2_s_q <= 2'h0;
            uv_s_q   <= 2'h0;
        end else if (clk_en) begin
            uart_s_q <= {uart_s_q[0], uart_mode_pin};
            drv1_s_q <= {drv1_s_q[0], drv1_fault_pin};
            drv2_s_q <= {drv2_s_q[0], drv2_fault_pin};
            uv_s_q   <= {uv_s_q[0], pump_uv_pin};
        end
    end

    assign uart_mode = uart_s_q[1];
    assign drv1_err  = drv1_s_q[1];
    assign drv2_err  = drv2_s_q[1];
    assign pump_uv   = uv_s_q[1];

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic                     wr_cfg;
    logic                     rd_stat;
    logic [`GCSB_CFG_W-1:0]   cfg_q;
    logic [`GCSB_STAT_W-1:0]  stat_q;
    logic [`GCSB_CNT_W-1:0]   cnt_q;
    logic                     locked;

    assign locked  = cfg_q[`GCSB_BIT_LOCK];
    assign wr_cfg  = clk_en && reg_wr_stb && (reg_addr == `GCSB_ADDR_CFG);
    assign rd_stat = clk_en && reg_rd_stb && (reg_addr == `GCSB_ADDR_STAT);

    // ------------------------------------------------------------------
    // global configuration
    // ------------------------------------------------------------------
    // only reset clears the lock, so a runaway host cannot unlock it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= `GCSB_CFG_RST;
        end else if (wr_cfg && !locked) begin
            cfg_q <= reg_wdata[`GCSB_CFG_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // global status, clear on read
    // ------------------------------------------------------------------
    // a live condition sets its flag every cycle, so set beats the clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= `GCSB_STAT_RST;
        end else if (clk_en) begin
            if (rd_stat) begin
                stat_q[`GCSB_BIT_RESET] <= 1'b0;
            end
            if (drv1_err) begin
                stat_q[`GCSB_BIT_DRV1] <= 1'b1;
            end else if (rd_stat) begin
                stat_q[`GCSB_BIT_DRV1] <= 1'b0;
            end
            if (drv2_err) begin
                stat_q[`GCSB_BIT_DRV2] <= 1'b1;
            end else if (rd_stat) begin
                stat_q[`GCSB_BIT_DRV2] <= 1'b0;
            end
            if (pump_uv) begin
                stat_q[`GCSB_BIT_UV] <= 1'b1;
            end else if (rd_stat) begin
                stat_q[`GCSB_BIT_UV] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // uart write counter
    // ------------------------------------------------------------------
    // every write strobed in uart mode with the clock enable high counts, locked ones too: the frame still arrived
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= `GCSB_CNT_RST;
        end else if (clk_en && reg_wr_stb && uart_mode) begin
            cnt_q <= cnt_q + `GCSB_CNT_ONE;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // status read returns the flags as they stood before the clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q  <= `GCSB_DATA_ZERO;
            reg_rvalid_q <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid_q <= reg_rd_stb;
            if (reg_rd_stb) begin
                unique case (reg_addr)
                    `GCSB_ADDR_CFG:  reg_rdata_q <= {20'h0, cfg_q};
                    `GCSB_ADDR_STAT: reg_rdata_q <= {28'h0, stat_q};
                    `GCSB_ADDR_WCNT: reg_rdata_q <= {24'h0, cnt_q};
                    default:         reg_rdata_q <= `GCSB_DATA_ZERO;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    logic sync_on;
    assign sync_on = cfg_q[`GCSB_BIT_SYNC] && motor1_load_mode && motor2_load_mode;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_low_q         <= `GCSB_CFG_LOW_RST;
            analog_test_pin_q <= 1'b0;
            motor1_dir_q      <= 1'b0;
            motor2_dir_q      <= 1'b0;
        end else if (clk_en) begin
            cfg_low_q         <= cfg_q[`GCSB_CFG_LOW_W-1:0];
            analog_test_pin_q <= cfg_q[`GCSB_BIT_TEST];
            motor1_dir_q      <= motor1_dir_req ^ cfg_q[`GCSB_BIT_INV1];
            motor2_dir_q      <= motor2_dir_req ^ cfg_q[`GCSB_BIT_INV2];
        end
    end

    // the faster motor follows the slower one only in load mode
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            motor1_slow_q    <= 1'b0;
            motor2_slow_q    <= 1'b0;
            driver_disable_q <= 1'b1;
        end else if (clk_en) begin
            motor1_slow_q    <= motor1_slow_req || (sync_on && motor2_slow_req);
            motor2_slow_q    <= motor2_slow_req || (sync_on && motor1_slow_req);
            driver_disable_q <= pump_uv;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    lock_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        locked |=> $stable(cfg_q))
        else $error("locked configuration changed");

    lock_stay_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        locked |=> locked [*3])
        else $error("lock released without reset");

    test_route_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && wr_cfg && !locked
        ##1 clk_en |=> analog_test_pin_q == $past(reg_wdata[`GCSB_BIT_TEST], 2))
        else $error("test pin route wrong");

    dir1_inv_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && cfg_q[`GCSB_BIT_INV1] |=> motor1_dir_q != $past(motor1_dir_req))
        else $error("motor 1 direction not inverted");

    dir2_inv_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && !cfg_q[`GCSB_BIT_INV2] |=> motor2_dir_q == $past(motor2_dir_req))
        else $error("motor 2 direction inverted");

    speed_sync_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && sync_on && motor2_slow_req |=> motor1_slow_q)
        else $error("faster motor not slowed");

    rst_flag_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_stat |=> !stat_q[`GCSB_BIT_RESET] && reg_rvalid_q)
        else $error("reset flag survived a read");

    drv1_keep_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && drv1_err |=> stat_q[`GCSB_BIT_DRV1])
        else $error("driver 1 fault flag lost");

    drv2_keep_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        stat_q[`GCSB_BIT_DRV2] && !rd_stat |=> stat_q[`GCSB_BIT_DRV2])
        else $error("driver 2 fault flag dropped early");

    pump_uv_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && pump_uv |=> driver_disable_q && stat_q[`GCSB_BIT_UV])
        else $error("undervoltage not flagged");

    cnt_inc_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && reg_wr_stb && uart_mode
        |=> cnt_q == 8'($past(cnt_q) + `GCSB_CNT_ONE))
        else $error("write counter did not step");

    cnt_read_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !reg_wr_stb |=> $stable(cnt_q))
        else $error("read changed write counter");

    cnt_spi_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !uart_mode |=> $stable(cnt_q))
        else $error("counter moved in spi mode");

    cnt_wrap_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clk_en && reg_wr_stb && uart_mode && cnt_q == `GCSB_CNT_MAX
        |=> cnt_q == `GCSB_CNT_RST)
        else $error("counter did not wrap");

    // a frozen clock enable must hide strobes from every register
    freeze_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !clk_en |=> $stable(cfg_q) && $stable(stat_q) && $stable(cnt_q))
        else $error("state moved while clock enable low");

    lock_write_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst) locked && wr_cfg);
    fault_read_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst) drv1_err && rd_stat);
    frozen_wr_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst) !clk_en && reg_wr_stb);
    cnt_wrap_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst)
        cnt_q == `GCSB_CNT_MAX ##1 cnt_q == `GCSB_CNT_RST);
    sync_slow_c: cover property (
        @(posedge sys_clk) disable iff (sys_rst) sync_on && motor1_slow_req);

endmodule
`default_nettype wire

// *** sim/gcsb_host_model.sv ***
// host controller model issuing register accesses to the bank
`default_nettype none
module gcsb_host_model (
    // clock
    input  wire logic                 sys_clk,
    // register port toward the bank
    output var  logic                 reg_wr_stb,
    output var  logic                 reg_rd_stb,
    output var  gcsb_pkg::gcsb_addr_t reg_addr,
    output var  gcsb_pkg::gcsb_data_t reg_wdata,
    input  wire gcsb_pkg::gcsb_data_t reg_rdata_q,
    input  wire logic                 reg_rvalid_q
);
    timeunit 1ns;
    timeprecision 100ps;
    import gcsb_pkg::*;

    logic allow_test;

    initial begin
        allow_test = 1'b0;
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_addr   = 7'h00;
        reg_wdata  = 32'h0000_0000;
    end

    task automatic wr(input gcsb_addr_t a, input gcsb_data_t d);
        @(posedge sys_clk);
        reg_wr_stb <= 1'b1;
        reg_addr   <= a;
        reg_wdata  <= (a == 7'h00 && !allow_test) ? (d & ~32'h0000_0080) : d;
        @(posedge sys_clk);
        reg_wr_stb <= 1'b0;
        // released lines must not look like a still-valid request
        reg_addr   <= ~a;
        reg_wdata  <= ~d;
    endtask

    task automatic rd(input gcsb_addr_t a, output gcsb_data_t d, output logic ok);
        @(posedge sys_clk);
        reg_rd_stb <= 1'b1;
        reg_addr   <= a;
        @(posedge sys_clk);
        reg_rd_stb <= 1'b0;
        reg_addr   <= ~a;
        #1;
        ok = reg_rvalid_q;
        d  = reg_rdata_q;
    endtask
endmodule
`default_nettype wire

// *** sim/test_global_config_status_bank.sv ***
// self-checking bench for the global configuration and status bank
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module test_global_config_status_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import gcsb_pkg::*;

    logic sys_clk, sys_rst, clk_en, uart_mode_pin, drv1_fault_pin, drv2_fault_pin, pump_uv_pin;
    logic m1_dir, m2_dir, m1_load, m2_load, m1_slow, m2_slow;
    logic reg_wr_stb, reg_rd_stb, reg_rvalid_q, analog_test_pin_q;
    logic motor1_dir_q, motor2_dir_q, motor1_slow_q, motor2_slow_q, driver_disable_q;
    logic [6:0] cfg_low_q;
    gcsb_addr_t reg_addr;
    gcsb_data_t reg_wdata, reg_rdata_q, v;
    logic [7:0] cnt;
    int err_count, n_checks, cyc;

    gcsb_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .uart_mode_pin(uart_mode_pin), .drv1_fault_pin(drv1_fault_pin),
        .drv2_fault_pin(drv2_fault_pin), .pump_uv_pin(pump_uv_pin),
        .motor1_dir_req(m1_dir), .motor2_dir_req(m2_dir), .motor1_load_mode(m1_load),
        .motor2_load_mode(m2_load), .motor1_slow_req(m1_slow), .motor2_slow_req(m2_slow),
        .cfg_low_q(cfg_low_q), .analog_test_pin_q(analog_test_pin_q),
        .motor1_dir_q(motor1_dir_q), .motor2_dir_q(motor2_dir_q),
        .motor1_slow_q(motor1_slow_q), .motor2_slow_q(motor2_slow_q),
        .driver_disable_q(driver_disable_q));

    gcsb_host_model i_host (.sys_clk(sys_clk), .reg_wr_stb(reg_wr_stb),
        .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));

    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // whole run is under a thousand cycles; the ceiling leaves wide margin
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    function automatic logic exp_slow(logic own, logic oth, logic sy, logic l1, logic l2);
        return own | (sy & l1 & l2 & oth);
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic rd_chk(input string nm, input gcsb_addr_t a, input gcsb_data_t ex);
        gcsb_data_t d;
        logic ok;
        i_host.rd(a, d, ok);
        `CHK({nm, " valid"}, 1'b1, ok)
        `CHK(nm, ex, d)
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cnt = 8'h00;
        // let the pin synchronisers fill before the first access
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic wr_cfg(input gcsb_data_t d);
        i_host.wr(7'h00, d);
        cnt = cnt + ((uart_mode_pin === 1'b1) ? 8'h01 : 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {sys_rst, clk_en, uart_mode_pin, drv1_fault_pin, drv2_fault_pin, pump_uv_pin} = 6'h30;
        {m1_dir, m2_dir, m1_load, m2_load, m1_slow, m2_slow} = 6'h00;
        err_count = 0;
        n_checks = 0;
        cyc = 0;
        void'($urandom(32'h8508));
        do_reset();
        rd_chk("status", 7'h01, 32'h1);
        rd_chk("status", 7'h01, 32'h0);
        rd_chk("config", 7'h00, 32'h0);
        wr_cfg(32'h0000_0123);
        rd_chk("count spi", 7'h02, 32'h0);
        uart_mode_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            v = $urandom & 32'h0000_037F;
            {m1_dir, m2_dir} <= 2'($urandom);
            wr_cfg(v);
            rd_chk("config", 7'h00, v);
            rd_chk("count", 7'h02, {24'h0, cnt});
            rd_chk("count", 7'h02, {24'h0, cnt});
            `CHK("low bits", v[6:0], cfg_low_q)
            `CHK("dir1", m1_dir ^ v[8], motor1_dir_q)
            `CHK("dir2", m2_dir ^ v[9], motor2_dir_q)
        end
        i_host.allow_test = 1'b1;
        wr_cfg(32'h0000_0080);
        `CHK("test pin on", 1'b1, analog_test_pin_q)
        i_host.allow_test = 1'b0;
        wr_cfg(32'h0000_0080);
        `CHK("test pin off", 1'b0, analog_test_pin_q)
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            {m1_load, m2_load, m1_slow, m2_slow} <= (i < 4) ? 4'hD : 4'($urandom);
            wr_cfg({20'h0, v[0], 11'h0});
            `CHK("slow1", exp_slow(m1_slow, m2_slow, v[0], m1_load, m2_load), motor1_slow_q)
            `CHK("slow2", exp_slow(m2_slow, m1_slow, v[0], m1_load, m2_load), motor2_slow_q)
        end
        for (int b = 1; b < 4; b++) begin
            {pump_uv_pin, drv2_fault_pin, drv1_fault_pin} <= 3'b001 << (b - 1);
            repeat (5) @(posedge sys_clk);
            #1;
            `CHK("disable", b == 3, driver_disable_q)
            rd_chk("status set", 7'h01, 32'h1 << b);
            rd_chk("status held", 7'h01, 32'h1 << b);
            {pump_uv_pin, drv2_fault_pin, drv1_fault_pin} <= 3'b000;
            repeat (5) @(posedge sys_clk);
            rd_chk("status latched", 7'h01, 32'h1 << b);
            rd_chk("status clear", 7'h01, 32'h0);
        end
        // a write strobed while the clock enable is low must not count or land
        clk_en <= 1'b0;
        i_host.wr(7'h00, 32'h0000_0040);
        clk_en <= 1'b1;
        rd_chk("count frozen", 7'h02, {24'h0, cnt});
        `CHK("low frozen", 7'h00, cfg_low_q)
        wr_cfg(32'h0000_0500);
        wr_cfg(32'h0000_0200);
        rd_chk("config locked", 7'h00, 32'h500);
        rd_chk("count locked", 7'h02, {24'h0, cnt});
        while (cnt != 8'hFF) begin
            i_host.wr(7'h7F, $urandom);
            cnt++;
        end
        rd_chk("count max", 7'h02, 32'hFF);
        rd_chk("unmapped", 7'h7F, 32'h0);
        i_host.wr(7'h02, $urandom);
        rd_chk("count wrap", 7'h02, 32'h0);
        do_reset();
        rd_chk("config reset", 7'h00, 32'h0);
        rd_chk("status reset", 7'h01, 32'h1);
        wr_cfg(32'h0000_0100);
        rd_chk("config unlocked", 7'h00, 32'h100);
        rd_chk("count reset", 7'h02, 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
